// ---- hdl/cordic_position_readout_params.svh ----
// offsets, field positions, reset values and counts of the position readout
`ifndef CORDIC_POSITION_READOUT_PARAMS_SVH
`define CORDIC_POSITION_READOUT_PARAMS_SVH

`define OFS_POLARITY      8'h13
`define OFS_SINE_AMP      8'h14
`define OFS_COSINE_AMP    8'h15
`define OFS_QUARTER_ANGLE 8'h16
`define OFS_MAGNITUDE     8'h17
`define OFS_FULL_TURN     8'h18
`define OFS_POS_PRECAL    8'h19
`define OFS_POS_POSTCAL   8'h1A

`define AMP_WIDTH         13
`define CORDIC_STEPS      16
`define POL_BIT_COS       1
`define POL_BIT_SIN       0
`define ANGLE_NINETY      17'h08000
`define ANGLE_MAX         15'h7FFF
`define ANGLE_HALF_TURN   17'h10000
`define SLOPE_FRAC_BITS   15
`define RESET_WORD        16'h0000

`endif

// ---- hdl/cordic_position_readout_pkg.sv ----
// types shared by the position readout
package cordic_position_readout_pkg;

	typedef enum logic [1:0] {
		st_idle,
		st_iterate,
		st_expand,
		st_commit
	} engine_state_t;

	typedef enum logic [1:0] {
		keep_to_bit1,
		keep_to_bit5,
		keep_to_bit7
	} output_lsb_t;

endpackage

// ---- hdl/cordic_position_readout.sv ----
// cordic angle, magnitude, full-turn angle and position shadow words
`timescale 1ns/1ps
`include "cordic_position_readout_params.svh"

// Overview of operation
// RULE1 - cosine amplitude word reads zero in bits 15..13, amplitude in bits 12..0
// RULE2 - quarter angle is arctan(sine/cosine) from exactly sixteen cordic steps
// RULE3 - vectoring mode rotates by fixed angles driving the cosine-axis residual to zero
// RULE4 - quarter angle word: bit 15 zero, 0x0000 is 0 and 0x7FFF is 90 degrees
// RULE5 - magnitude is root of summed squares divided by gain constant 0.607
// RULE6 - magnitude word: bit 15 zero, fifteen-bit magnitude value
// RULE7 - polarity bits extend quarter angle to a 17-bit full-turn angle
// RULE8 - full-turn angle is read as its upper sixteen bits
// RULE9 - full-turn word is uncalibrated, 0x0000 to 0xFFFF over 360 degrees
// RULE10 - reader compares quarter angle bits 14..1 against the full-turn word
// RULE11 - first position word applies linearity correction before slope/offset calibration
// RULE12 - second position word applies calibration then linearity correction
// RULE13 - with correction mode 0 the second position equals the first
// RULE14 - protocol position truncated to bit 1, 5 or 7, optionally rounded
// RULE15 - result words are read-only and have no reset value
// RULE16 - two status bits carry cosine and sine phase polarity used for position
// RULE17 - sine amplitude word holds 13-bit amplitude low, upper bits zero
// RULE18 - all result words update together when the computation finishes; amplitude and polarity words update at sample take instead
module cordic_position_readout
	import cordic_position_readout_pkg::*;
#(
	parameter int AMP_W = `AMP_WIDTH,
	parameter int STEPS = `CORDIC_STEPS
) (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              sample_valid,
	input  wire logic [AMP_W-1:0]  x_sin_amp,
	input  wire logic [AMP_W-1:0]  y_cos_amp,
	input  wire logic              x_sin_pol,
	input  wire logic              y_cos_pol,
	input  wire logic              corr_mode,
	input  wire logic [15:0]       cal_offset,
	input  wire logic [15:0]       cal_slope,
	input  wire logic [15:0]       lin_corr,
	input  wire output_lsb_t       out_lsb_sel,
	input  wire logic              out_round,
	input  wire logic              rd_en,
	input  wire logic [7:0]        rd_addr,
	output logic [15:0]            rd_data,
	output logic                   rd_valid,
	output logic                   busy,
	output logic                   result_done,
	output logic [15:0]            prot_position
);

	////////////////////////////////////////////////////////////////////////////
	// arctangent step table, units of 90 degrees / 32768

	function automatic logic [16:0] atan_step(input logic [3:0] i);
		case (i)
			4'h0:    atan_step = 17'h04000;
			4'h1:    atan_step = 17'h025C8;
			4'h2:    atan_step = 17'h013F6;
			4'h3:    atan_step = 17'h00A22;
			4'h4:    atan_step = 17'h00516;
			4'h5:    atan_step = 17'h0028C;
			4'h6:    atan_step = 17'h00146;
			4'h7:    atan_step = 17'h000A3;
			4'h8:    atan_step = 17'h00051;
			4'h9:    atan_step = 17'h00029;
			4'hA:    atan_step = 17'h00014;
			4'hB:    atan_step = 17'h0000A;
			4'hC:    atan_step = 17'h00005;
			4'hD:    atan_step = 17'h00003;
			4'hE:    atan_step = 17'h00001;
			default: atan_step = 17'h00001;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// engine state

	// guard bits below the amplitude keep shift truncation from eating the angle
	localparam int GUARD = 8;
	localparam int ACC_W = AMP_W + GUARD + 3;

	engine_state_t            state;
	engine_state_t            next_state;
	logic signed [ACC_W-1:0]  x_acc;
	logic signed [ACC_W-1:0]  next_x_acc;
	logic signed [ACC_W-1:0]  y_acc;
	logic signed [ACC_W-1:0]  next_y_acc;
	logic signed [ACC_W-1:0]  mag_full;
	logic [16:0]        z_acc;
	logic [16:0]        next_z_acc;
	logic [3:0]         step;
	logic [3:0]         next_step;
	logic               sin_pos;
	logic               next_sin_pos;
	logic               cos_pos;
	logic               next_cos_pos;
	logic [16:0]        spa_work;
	logic [16:0]        next_spa_work;
	logic [14:0]        angle_work;
	logic [14:0]        next_angle_work;
	logic               done_q;
	logic               next_done_q;
	logic [16:0]        quarter17;

	// shadow words, deliberately without reset value
	logic [AMP_W-1:0]   sin_amp_q;
	logic [AMP_W-1:0]   cos_amp_q;
	logic [1:0]         pol_q;
	logic [14:0]        angle_q;
	logic [14:0]        mag_q;
	logic [16:0]        spa_q;
	logic [15:0]        position_precal_corrected_q;
	logic [15:0]        position_postcal_corrected_q;
	logic [15:0]        next_position_precal_corrected;
	logic [15:0]        next_position_postcal_corrected;
	logic [15:0]        spa16;
	logic [15:0]        cal_diff;
	logic [31:0]        cal_prod;
	logic [15:0]        cal_pos;

	// one vectoring step per clock; x carries the sine and y the cosine, so the
	// cosine residual is what gets nulled and z collects arctan(cos/sin)
	always_comb begin
		next_state      = state;
		next_x_acc      = x_acc;
		next_y_acc      = y_acc;
		next_z_acc      = z_acc;
		next_step       = step;
		next_sin_pos    = sin_pos;
		next_cos_pos    = cos_pos;
		next_spa_work   = spa_work;
		next_angle_work = angle_work;
		next_done_q     = 1'b0;
		quarter17       = `ANGLE_NINETY - z_acc;
		case (state)
			st_idle: begin
				if (sample_valid) begin
					next_x_acc   = {3'b000, x_sin_amp, {GUARD{1'b0}}};
					next_y_acc   = {3'b000, y_cos_amp, {GUARD{1'b0}}};
					next_z_acc   = '0;
					next_step    = '0;
					next_sin_pos = x_sin_pol; // RULE16
					next_cos_pos = y_cos_pol; // RULE16
					next_state   = st_iterate;
				end
			end
			st_iterate: begin
				if (y_acc > 0) begin // RULE3
					next_x_acc = x_acc + (y_acc >>> step);
					next_y_acc = y_acc - (x_acc >>> step);
					next_z_acc = z_acc + atan_step(step);
				end else begin
					next_x_acc = x_acc - (y_acc >>> step);
					next_y_acc = y_acc + (x_acc >>> step);
					next_z_acc = z_acc - atan_step(step);
				end
				next_step = step + 4'd1;
				if (32'(step) == STEPS - 1) begin // RULE2
					next_state = st_expand;
				end
			end
			st_expand: begin
				// 90 degrees minus the complement; a negative complement clamps to
				// 0x7FFF, one past 90 degrees clamps to 0 instead of wrapping high
				if (z_acc[16] || z_acc == '0) begin // RULE4
					next_angle_work = `ANGLE_MAX;
				end else if (z_acc > `ANGLE_NINETY) begin
					next_angle_work = '0;
				end else begin
					next_angle_work = quarter17[14:0];
				end
				next_state = st_commit;
			end
			st_commit: begin
				next_done_q = 1'b1;
				next_state  = st_idle;
			end
			default: begin
				next_state = st_idle;
			end
		endcase
		// quadrant from the two polarities, 17-bit turn wraps at 360 degrees
		case ({cos_pos, sin_pos}) // RULE7
			2'b11:   next_spa_work = (state == st_expand) ? 17'(next_angle_work) : spa_work;
			2'b01:   next_spa_work = (state == st_expand) ?
				`ANGLE_HALF_TURN - 17'(next_angle_work) : spa_work;
			2'b00:   next_spa_work = (state == st_expand) ?
				`ANGLE_HALF_TURN + 17'(next_angle_work) : spa_work;
			default: next_spa_work = (state == st_expand) ?
				17'h00000 - 17'(next_angle_work) : spa_work;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state      <= st_idle;
			x_acc      <= '0;
			y_acc      <= '0;
			z_acc      <= '0;
			step       <= '0;
			sin_pos    <= 1'b0;
			cos_pos    <= 1'b0;
			spa_work   <= '0;
			angle_work <= '0;
			done_q     <= 1'b0;
		end else begin
			state      <= next_state;
			x_acc      <= next_x_acc;
			y_acc      <= next_y_acc;
			z_acc      <= next_z_acc;
			step       <= next_step;
			sin_pos    <= next_sin_pos;
			cos_pos    <= next_cos_pos;
			spa_work   <= next_spa_work;
			angle_work <= next_angle_work;
			done_q     <= next_done_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// position words from the full-turn angle

	// the slope product is Q1.15; offset subtraction wraps modulo one turn
	always_comb begin
		// trim the cordic gain (about 1.6468) up to 1/0.607 with a few shifted adds
		mag_full = x_acc + (x_acc >>> 12) + (x_acc >>> 13) + (x_acc >>> 15) + (x_acc >>> 16);
		spa16    = spa_work[16:1]; // RULE8
		cal_diff = spa16 - cal_offset;
		cal_prod = cal_diff * cal_slope;
		cal_pos  = cal_prod[`SLOPE_FRAC_BITS+15:`SLOPE_FRAC_BITS];
		next_position_precal_corrected = spa16 + lin_corr; // RULE11
		if (corr_mode) begin
			next_position_postcal_corrected = cal_pos + lin_corr; // RULE12
		end else begin
			next_position_postcal_corrected = next_position_precal_corrected; // RULE13
		end
	end

	// angle, magnitude, full-turn and position words move in the commit cycle; amplitude and polarity words move at sample take
	always_ff @(posedge clk) begin
		if (state == st_idle && sample_valid) begin
			sin_amp_q <= x_sin_amp; // RULE17
			cos_amp_q <= y_cos_amp; // RULE1
			pol_q     <= {y_cos_pol, x_sin_pol}; // RULE16
		end
		if (state == st_commit) begin // RULE18
			angle_q <= angle_work;
			mag_q   <= mag_full[GUARD+14:GUARD]; // RULE5
			spa_q   <= spa_work; // RULE9
			position_precal_corrected_q  <= next_position_precal_corrected;
			position_postcal_corrected_q  <= next_position_postcal_corrected;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read port; angle, magnitude, full-turn and position words have no reset value until the first commit

	logic [15:0] next_rd_data;
	logic        next_rd_valid;

	always_comb begin
		next_rd_valid = rd_en;
		next_rd_data  = rd_data;
		if (rd_en) begin
			case (rd_addr) // RULE15
				`OFS_POLARITY:      next_rd_data = {14'h0000, pol_q};
				`OFS_SINE_AMP:      next_rd_data = 16'(sin_amp_q); // RULE17
				`OFS_COSINE_AMP:    next_rd_data = 16'(cos_amp_q); // RULE1
				`OFS_QUARTER_ANGLE: next_rd_data = {1'b0, angle_q}; // RULE4
				`OFS_MAGNITUDE:     next_rd_data = {1'b0, mag_q}; // RULE6
				`OFS_FULL_TURN:     next_rd_data = spa_q[16:1]; // RULE8
				`OFS_POS_PRECAL:    next_rd_data = position_precal_corrected_q;
				`OFS_POS_POSTCAL:   next_rd_data = position_postcal_corrected_q;
				default:            next_rd_data = `RESET_WORD;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rd_data  <= `RESET_WORD;
			rd_valid <= 1'b0;
		end else begin
			rd_data  <= next_rd_data;
			rd_valid <= next_rd_valid;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// protocol position: keep bits 15 down to 1, 5 or 7, right aligned

	logic [15:0] next_prot;
	logic [16:0] rounded;
	logic [3:0]  keep_lsb;
	logic        next_busy;

	// rounding saturates at full scale rather than wrapping back to zero
	always_comb begin
		case (out_lsb_sel) // RULE14
			keep_to_bit1: keep_lsb = 4'd1;
			keep_to_bit5: keep_lsb = 4'd5;
			keep_to_bit7: keep_lsb = 4'd7;
			default:      keep_lsb = 4'd1;
		endcase
		rounded = 17'(position_postcal_corrected_q >> keep_lsb);
		if (out_round) begin
			rounded = rounded + 17'(position_postcal_corrected_q[keep_lsb-4'd1]);
		end
		if (rounded > 17'(16'hFFFF >> keep_lsb)) begin
			next_prot = 16'hFFFF >> keep_lsb;
		end else begin
			next_prot = rounded[15:0];
		end
		next_busy = (next_state != st_idle);
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prot_position <= `RESET_WORD;
			busy          <= 1'b0;
			result_done   <= 1'b0;
		end else begin
			prot_position <= next_prot;
			busy          <= next_busy;
			result_done   <= done_q;
		end
	end

endmodule

// ---- bench/cordic_position_readout_props.sv ----
// port-level checks of the position readout
`timescale 1ns/1ps
module position_readout_props
	import cordic_position_readout_pkg::*;
(
	input	wire logic		clk,
	input	wire logic		rst_n,
	input	wire logic		busy,
	input	wire logic		result_done,
	input	wire logic		rd_en,
	input	wire logic [7:0]	rd_addr,
	input	wire logic [15:0]	rd_data,
	input	wire logic		rd_valid,
	input	wire output_lsb_t	out_lsb_sel,
	input	wire logic [15:0]	prot_position
);
	logic	seen;
	logic	next_seen;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// output words are undefined until the first commit, so gate on one
	always_comb next_seen = rst_n & (seen | result_done);
	always_ff @(posedge clk) seen <= next_seen;
	////////////////////////////////////////////////////////////////////////
	sequence s_take;
		$rose(busy);
	endsequence
	sequence s_commit;
		##19 $rose(result_done);
	endsequence
	chk_sixteen_steps: assert property (s_take |-> s_commit)
		else $error("result late or early after take");
	chk_busy_hold: assert property (s_take |-> busy[*8] ##1 busy[*8] ##1 busy[*2] ##1 !busy)
		else $error("busy dropped during iteration");
	chk_done_pulse: assert property (result_done |=> !result_done)
		else $error("done longer than one cycle");
	chk_done_idle: assert property (result_done |-> !$past(busy) && $past(busy, 2))
		else $error("done without busy run");
	chk_read_answer: assert property (rd_en |=> rd_valid)
		else $error("read not answered");
	chk_cos_top: assert property (rd_en && rd_addr == 8'h15 |=> rd_data[15:13] == 3'h0)
		else $error("cosine word top bits set");
	chk_sin_top: assert property (rd_en && rd_addr == 8'h14 |=> rd_data[15:13] == 3'h0)
		else $error("sine word top bits set");
	chk_angle_top: assert property (rd_en && rd_addr == 8'h16 |=> !rd_data[15])
		else $error("angle bit 15 set");
	chk_mag_top: assert property (rd_en && rd_addr == 8'h17 |=> !rd_data[15])
		else $error("magnitude bit 15 set");
	chk_pol_word: assert property (rd_en && rd_addr == 8'h13 |=> rd_data[15:2] == 14'h0)
		else $error("polarity word upper bits set");
	chk_prot_width: assert property (seen && $past(out_lsb_sel) == keep_to_bit7
		|-> prot_position[15:9] == 7'h00)
		else $error("protocol word too wide");
endmodule
bind cordic_position_readout position_readout_props u_props (.clk, .rst_n, .busy,
	.result_done, .rd_en, .rd_addr, .rd_data, .rd_valid, .out_lsb_sel, .prot_position);

// ---- bench/coil_frontend_model.sv ----
// demodulator and sampler front end handing amplitude pairs over
`timescale 1ns/1ps
module coil_frontend_model (
	input	wire logic		clk,
	input	wire logic		busy,
	output	logic			sample_valid,
	output	logic [12:0]	x_sin_amp,
	output	logic [12:0]	y_cos_amp,
	output	logic			x_sin_pol,
	output	logic			y_cos_pol
);
	bit	live;
	initial begin
		sample_valid = 1'b0;
		{x_sin_amp, y_cos_amp, x_sin_pol, y_cos_pol} = 28'h0;
	end
	// between pairs the lines toggle, so a stale pair can never look valid
	always @(negedge clk) if (!live) {x_sin_amp, y_cos_amp} = ~{x_sin_amp, y_cos_amp};
	// one pulse per pair once idle; dup sends a stray pulse mid-run
	task automatic send(input logic [12:0] s, c, input logic sp, cp, input int dly,
		input bit dup);
		int i;
		repeat (dly) @(negedge clk);
		for (i = 0; i < 64 && busy; i++) @(negedge clk);
		live = 1'b1;
		{x_sin_amp, y_cos_amp, x_sin_pol, y_cos_pol} = {s, c, sp, cp};
		sample_valid = 1'b1;
		@(negedge clk);
		sample_valid = 1'b0;
		if (dup) begin
			repeat (4) @(negedge clk);
			x_sin_amp = ~s;
			sample_valid = 1'b1;
			@(negedge clk);
			sample_valid = 1'b0;
		end
		live = 1'b0;
	endtask
endmodule

// ---- bench/cordic_position_readout_tb_top.sv ----
// self-checking bench of the cordic position readout
`timescale 1ns/1ps
module cordic_position_readout_tb_top import cordic_position_readout_pkg::*;;
	logic		clk, rst_n, sample_valid, x_sin_pol, y_cos_pol, busy, result_done;
	logic		corr_mode, out_round, rd_en, rd_valid;
	logic [12:0]	x_sin_amp, y_cos_amp;
	logic [15:0]	cal_offset, cal_slope, lin_corr, rd_data, prot_position;
	logic [7:0]	rd_addr;
	output_lsb_t	out_lsb_sel;
	int		n_mismatch, cmp_count, cyc;
	// corners {sine, cosine, pols}: full sine, 45 deg, zero sine, third quadrant
	logic [27:0]	tab [4] = '{{13'h1FFF, 13'h0000, 2'h3}, {13'h1FFF, 13'h1FFF, 2'h3},
		{13'h0000, 13'h1FFF, 2'h3}, {13'h1FFF, 13'h0000, 2'h0}};
	cordic_position_readout dut (.clk, .rst_n, .sample_valid, .x_sin_amp, .y_cos_amp,
		.x_sin_pol, .y_cos_pol, .corr_mode, .cal_offset, .cal_slope, .lin_corr,
		.out_lsb_sel, .out_round, .rd_en, .rd_addr, .rd_data, .rd_valid, .busy,
		.result_done, .prot_position);
	coil_frontend_model fe (.clk, .busy, .sample_valid, .x_sin_amp, .y_cos_amp,
		.x_sin_pol, .y_cos_pol);
	////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic test_done();
		if (n_mismatch == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// hang guard: the full run needs well under a thousand cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			test_done();
		end
	end
	task automatic check(input logic [15:0] d, e);
		cmp_count++;
		if (d !== e) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h want %h", $time, d, e);
		end
	endtask
	// cordic rounding leaves a few codes of error; compare modulo a full turn
	task automatic near(input logic [15:0] d, e, input int t);
		logic [15:0] df;
		df = d - e;
		if (df <= t || df >= 17'h10000 - t) check(d, d);
		else check(d, e);
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		rd_en = 1'b1;
		rd_addr = a;
		@(negedge clk);
		check(16'(rd_valid), 16'h0001);
		d = rd_data;
	endtask
	function automatic logic [14:0] exp_ang(input logic [12:0] s, c);
		real r;
		r = $atan2(real'(s), real'(c)) * 32768.0 / 1.5707963;
		return (r > 32767.0) ? 15'h7FFF : 15'(int'(r));
	endfunction
	// quadrant from the polarities, 17-bit turn kept as its upper 16 bits
	function automatic logic [15:0] exp_spa(input logic [14:0] a, input logic sp, cp);
		logic [16:0] q;
		case ({cp, sp})
			2'b11: q = {2'h0, a};
			2'b01: q = 17'h10000 - a;
			2'b00: q = 17'h10000 + a;
			default: q = 17'h00000 - a;
		endcase
		return q[16:1];
	endfunction
	function automatic logic [15:0] exp_prot(input logic [15:0] p, input output_lsb_t s,
		input logic r);
		int n;
		logic [16:0] v;
		n = (s == keep_to_bit5) ? 5 : (s == keep_to_bit7) ? 7 : 1;
		v = (p >> n) + (r & p[n-1]);
		return (v > (17'h0FFFF >> n)) ? 16'(17'h0FFFF >> n) : v[15:0];
	endfunction
	////////////////////////////////////////////////////////////////////////
	initial begin
		logic [12:0] s, c;
		logic [14:0] a;
		logic [15:0] d, e, p0, p1, ang;
		logic [31:0] pp;
		logic spl, cpl;
		int i;
		{rst_n, rd_en, corr_mode, out_round} = 4'h0;
		{rd_addr, cal_offset, lin_corr} = 40'h0;
		cal_slope = 16'h8000;
		out_lsb_sel = keep_to_bit1;
		void'($urandom(79371));
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		for (int k = 0; k < 16; k++) begin
			{s, c, spl, cpl} = (k < 4) ? tab[k] : {13'($urandom_range(13'h1FFF, 13'h0001)),
				13'($urandom_range(13'h1FFF, 13'h0001)), 2'($urandom)};
			corr_mode = k[0];
			out_lsb_sel = output_lsb_t'(k % 3);
			out_round = k[1];
			cal_offset = 16'($urandom);
			cal_slope = 16'($urandom_range(16'h8000, 16'h4000));
			lin_corr = 16'($urandom);
			fe.send(s, c, spl, cpl, k % 4, k == 5);
			for (i = 0; i < 40 && result_done !== 1'b1; i++) @(negedge clk);
			check(16'(i), (k == 5) ? 16'h000E : 16'h0013);
			a = exp_ang(s, c);
			rd(8'h13, d); check(d, {14'h0, cpl, spl});
			rd(8'h14, d); check(d, {3'h0, s});
			rd(8'h15, d); check(d, {3'h0, c});
			rd(8'h16, ang); near(ang, {1'b0, a}, 4);
			e = 16'(int'($sqrt(real'(s) ** 2 + real'(c) ** 2) / 0.607));
			rd(8'h17, d); near(d, e, 8);
			e = exp_spa(a, spl, cpl);
			rd(8'h18, d); near(d, e, 3);
			// first quadrant: the full-turn word is the angle with its lsb dropped
			if ({cpl, spl} == 2'b11) check(d, {2'h0, ang[14:1]});
			p0 = e + lin_corr;
			rd(8'h19, d); near(d, p0, 4);
			pp = 16'(e - cal_offset) * cal_slope;
			p1 = corr_mode ? pp[30:15] + lin_corr : p0;
			rd(8'h1A, d); near(d, p1, 6);
			near(prot_position, exp_prot(p1, out_lsb_sel, out_round), 4);
			rd(8'h20, d); check(d, 16'h0000);
			rd_en = 1'b0;
		end
		test_done();
	end
endmodule
